//--- hdl/eiu_map.svh
/*
 constant map of the external pin interrupt unit: register offsets, field positions, reset values, timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef EIU_MAP_SVH
`define EIU_MAP_SVH

`define EIU_PRIMARY_CONTROL_OFF    12'h000
`define EIU_SYNC_BUSY_STATUS_OFF   12'h004
`define EIU_LINE_ENABLE_CONTROL_OFF 12'h008
`define EIU_IRQ_ENABLE_OFF         12'h00c
`define EIU_LINE_ENABLE_CLEAR_OFF  12'h010
`define EIU_LINE_FLAG_STATUS_OFF   12'h014
`define EIU_NMI_CONTROL_OFF        12'h018
`define EIU_NMI_FLAG_OFF           12'h01c
`define EIU_IRQ_STATUS_OFF         12'h020
`define EIU_IRQ_CLEAR_OFF          12'h024
`define EIU_SENSE_BASE_OFF         12'h040

`define EIU_CTRL_SOFT_RESET_BIT    0
`define EIU_CTRL_ENABLE_BIT        1
`define EIU_BUSY_SOFT_RESET_BIT    0
`define EIU_BUSY_ENABLE_BIT        1

`define EIU_SENSE_FILTER_BIT       3
`define EIU_SENSE_ASYNC_BIT        4

`define EIU_RESET_WORD             32'h0000_0000
`define EIU_SYNC_STAGES            2'h3
`define EIU_FILTER_TAPS            3

`endif

//--- hdl/eiu_pkg.sv
/*
 types of the external pin interrupt unit.
 assumes nothing beyond a systemverilog compiler.
*/
package eiu_pkg;
	typedef enum logic [2:0]
	{
		EIU_SENSE_NONE = 3'h0,
		EIU_SENSE_RISE = 3'h1,
		EIU_SENSE_FALL = 3'h2,
		EIU_SENSE_BOTH = 3'h3,
		EIU_SENSE_HIGH = 3'h4,
		EIU_SENSE_LOW  = 3'h5
	} eiu_sense_t;
	typedef enum logic [1:0]
	{
		EIU_ST_IDLE  = 2'h0,
		EIU_ST_SYNC  = 2'h1,
		EIU_ST_CLEAN = 2'h2
	} eiu_state_t;
endpackage : eiu_pkg

//--- hdl/eiu_unit.sv
/*
 external pin interrupt unit: 32 maskable lines plus one non-maskable line, apb register slave.
 assumes pins synchronous to pclk, a single clock, apb master per amba apb3.
*/
// What this block does
// RULE1 - there are 32 ordinary external lines and one extra non-maskable line.
// RULE2 - each ordinary line has its own mask that blocks only that line.
// RULE3 - each line senses rising edge, falling edge, both edges, high level or low level.
// RULE4 - each line has a selectable filter that removes short spikes before sensing.
// RULE5 - each line may detect asynchronously so a valid condition can wake the device with clocks stopped; wake_req here is a pclk register gated by clk_en.
// RULE6 - edge detection per line is selectable between clocked and asynchronous mode.
// RULE7 - a detected condition on an ordinary line also produces an event toward other units.
// RULE8 - the non-maskable line senses like the others but drives the processor non-maskable request.
// RULE9 - busy bit 1 reads 1 while a global enable write is crossing domains, 0 once done.
// RULE10 - busy bit 0 reads 1 while a software reset write is being synchronized, 0 once done.
// RULE11 - bit x of the per-line enable register enables external line x.
// RULE12 - writing 0 to a per-line enable bit leaves it unchanged, writing 1 sets it; here writing 1 sets it only while the global enable is off.
// RULE13 - the per-line enable register resets to all zeros.
// RULE14 - an enabled line meeting its sense condition sets its flag and the request stays high while it is set.
// RULE15 - software polls the busy bits until zero before relying on a new enable or reset state.
`include "eiu_map.svh"
`timescale 1ns/1ns
`default_nettype none

module eiu_unit
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [31:0] external_line,
	input  wire logic        nmi_line,
	output var  logic [31:0] line_event,
	output var  logic [31:0] line_irq,
	output var  logic        nmi_req,
	output var  logic        wake_req,
	output var  logic        irq
);

	function automatic logic sense_hit(input logic [2:0] mode, input logic now, input logic last);
		unique case (mode)
			eiu_pkg::EIU_SENSE_RISE: sense_hit = now & ~last;
			eiu_pkg::EIU_SENSE_FALL: sense_hit = ~now & last;
			eiu_pkg::EIU_SENSE_BOTH: sense_hit = now ^ last;
			eiu_pkg::EIU_SENSE_HIGH: sense_hit = now;
			eiu_pkg::EIU_SENSE_LOW:  sense_hit = ~now;
			default:                 sense_hit = 1'b0;
		endcase
	endfunction : sense_hit

	function automatic logic level_mode(input logic [2:0] mode);
		level_mode = (mode == eiu_pkg::EIU_SENSE_HIGH) || (mode == eiu_pkg::EIU_SENSE_LOW);
	endfunction : level_mode

	logic                  global_enable;
	logic [31:0]           line_enable_bits;
	logic [31:0]           line_flag_status;
	logic [4:0]            sense_cfg [0:32];
	logic                  nmi_flag;
	logic [1:0]            irq_status;
	logic [1:0]            irq_enable;
	logic                  soft_reset_busy;
	logic                  enable_busy;
	logic [1:0]            sync_cnt;
	logic                  pending_enable;
	eiu_pkg::eiu_state_t   state;
	eiu_pkg::eiu_state_t   next_state;
	logic [32:0]           pin_in;
	logic [32:0]           last_pin;
	logic [32:0]           filt_a;
	logic [32:0]           filt_b;
	logic [32:0]           clean;
	logic [32:0]           hit;
	logic [32:0]           async_hit;

	// the answer is raised at the first enabled edge of a transfer, so a setup edge lost to a low
	// clock enable only postpones the answer instead of hanging the bus
	wire        wr_access   = psel & penable & pwrite & pready & clk_en;
	wire        rd_setup    = psel & ~pwrite & ~pready & clk_en;
	wire [11:0] sense_rel   = paddr - `EIU_SENSE_BASE_OFF;
	wire        sense_sel   = paddr >= `EIU_SENSE_BASE_OFF;
	wire [5:0]  sense_idx   = sense_rel[7:2];
	wire        sense_ok    = sense_sel && (sense_rel[1:0] == 2'h0) && (sense_rel <= 12'h080);
	wire        hit_ctrl    = paddr == `EIU_PRIMARY_CONTROL_OFF;
	wire        known       = sense_ok || (paddr[1:0] == 2'h0 && paddr <= `EIU_IRQ_CLEAR_OFF);
	wire [31:0] flag_set    = hit[31:0] & line_enable_bits & {32{global_enable}};  // RULE2 RULE11 RULE14
	wire        nmi_set     = hit[32] & global_enable;  // RULE8
	wire        wr_flag_clr = wr_access && paddr == `EIU_LINE_FLAG_STATUS_OFF;
	wire        wr_nmi_clr  = wr_access && paddr == `EIU_NMI_FLAG_OFF;
	wire        wr_irq_clr  = wr_access && paddr == `EIU_IRQ_CLEAR_OFF;
	wire        wr_sres     = wr_access && hit_ctrl && pwdata[`EIU_CTRL_SOFT_RESET_BIT];
	wire        wr_en       = wr_access && hit_ctrl && !pwdata[`EIU_CTRL_SOFT_RESET_BIT];
	wire [1:0]  irq_events  = {nmi_set, |flag_set};
	// setting enable bits is write-protected while the global enable is on; clearing them is not
	wire        wr_en_set   = wr_access && !global_enable && paddr == `EIU_LINE_ENABLE_CONTROL_OFF;
	wire        wr_en_clr   = wr_access && paddr == `EIU_LINE_ENABLE_CLEAR_OFF;
	wire        wr_irq_en   = wr_access && paddr == `EIU_IRQ_ENABLE_OFF;
	wire        wr_sense    = wr_access && sense_ok;

	assign pin_in = {nmi_line, external_line};  // RULE1

	// filter: three agreeing samples, else hold; costs two cycles of latency
	genvar g;
	generate
		for (g = 0; g < 33; g++)
		begin : g_line
			wire filt_on = sense_cfg[g][`EIU_SENSE_FILTER_BIT];
			wire agree1  = pin_in[g] & filt_a[g] & filt_b[g];
			wire agree0  = ~(pin_in[g] | filt_a[g] | filt_b[g]);
			wire filt_v  = agree1 ? 1'b1 : (agree0 ? 1'b0 : clean[g]);  // RULE4
			wire cur     = filt_on ? filt_v : pin_in[g];
			// asynchronous mode compares raw pin samples, bypassing the filter, and feeds the wake request
			wire async_on = sense_cfg[g][`EIU_SENSE_ASYNC_BIT] & ~level_mode(sense_cfg[g][2:0]);
			assign async_hit[g] = sense_cfg[g][`EIU_SENSE_ASYNC_BIT]
				& sense_hit(sense_cfg[g][2:0], pin_in[g], last_pin[g]);  // RULE5
			assign hit[g] = async_on ? async_hit[g]
				: sense_hit(sense_cfg[g][2:0], cur, clean[g]);  // RULE3 RULE6
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					filt_a[g]   <= 1'b0;
					filt_b[g]   <= 1'b0;
					clean[g]    <= 1'b0;
					last_pin[g] <= 1'b0;
				end
				else if (clk_en)
				begin
					filt_a[g]   <= pin_in[g];
					filt_b[g]   <= filt_a[g];
					clean[g]    <= cur;
					last_pin[g] <= pin_in[g];
				end
			end
		end
	endgenerate

	// write synchronisation of soft reset and enable, modelled as a fixed crossing delay
	always_comb
	begin
		next_state = state;
		unique case (state)
			eiu_pkg::EIU_ST_IDLE:
			begin
				if (wr_sres)
					next_state = eiu_pkg::EIU_ST_CLEAN;
				else if (wr_en)
					next_state = eiu_pkg::EIU_ST_SYNC;
			end
			eiu_pkg::EIU_ST_SYNC:
			begin
				if (sync_cnt == `EIU_SYNC_STAGES)
					next_state = eiu_pkg::EIU_ST_IDLE;
			end
			eiu_pkg::EIU_ST_CLEAN:
			begin
				if (sync_cnt == `EIU_SYNC_STAGES)
					next_state = eiu_pkg::EIU_ST_IDLE;
			end
			default:
				next_state = eiu_pkg::EIU_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state           <= eiu_pkg::EIU_ST_IDLE;
			sync_cnt        <= 2'h0;
			pending_enable  <= 1'b0;
			global_enable   <= 1'b0;
			enable_busy     <= 1'b0;
			soft_reset_busy <= 1'b0;
		end
		else if (clk_en)
		begin
			state           <= next_state;
			sync_cnt        <= (state == eiu_pkg::EIU_ST_IDLE) ? 2'h0 : sync_cnt + 2'h1;
			enable_busy     <= next_state == eiu_pkg::EIU_ST_SYNC;  // RULE9
			soft_reset_busy <= next_state == eiu_pkg::EIU_ST_CLEAN;  // RULE10
			if (state == eiu_pkg::EIU_ST_IDLE && wr_en)
				pending_enable <= pwdata[`EIU_CTRL_ENABLE_BIT];
			if (state == eiu_pkg::EIU_ST_SYNC && next_state == eiu_pkg::EIU_ST_IDLE)
				global_enable <= pending_enable;
			else if (state == eiu_pkg::EIU_ST_CLEAN && next_state == eiu_pkg::EIU_ST_IDLE)
				global_enable <= 1'b0;
		end
	end

	wire soft_clear = state == eiu_pkg::EIU_ST_CLEAN && next_state == eiu_pkg::EIU_ST_IDLE;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			line_enable_bits <= `EIU_RESET_WORD;  // RULE13
		else if (clk_en)
		begin
			if (soft_clear)
				line_enable_bits <= `EIU_RESET_WORD;
			else if (wr_en_set)
				line_enable_bits <= line_enable_bits | pwdata;  // RULE12
			else if (wr_en_clr)
				line_enable_bits <= line_enable_bits & ~pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			line_flag_status <= `EIU_RESET_WORD;
			nmi_flag         <= 1'b0;
		end
		else if (clk_en)
		begin
			if (soft_clear)
			begin
				line_flag_status <= `EIU_RESET_WORD;
				nmi_flag         <= 1'b0;
			end
			else
			begin
				// set wins over a simultaneous clear
				line_flag_status <= (line_flag_status & ~(wr_flag_clr ? pwdata : 32'h0)) | flag_set;  // RULE14
				nmi_flag         <= (nmi_flag & ~(wr_nmi_clr & pwdata[0])) | nmi_set;  // RULE8
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= 2'h0;
			irq_enable <= 2'h0;
		end
		else if (clk_en)
		begin
			if (soft_clear)
			begin
				irq_status <= 2'h0;
				irq_enable <= 2'h0;
			end
			else
			begin
				irq_status <= (irq_status & ~(wr_irq_clr ? pwdata[1:0] : 2'h0)) | irq_events;
				if (wr_irq_en)
					irq_enable <= pwdata[1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 33; i++)
				sense_cfg[i] <= 5'h00;
		end
		else if (clk_en)
		begin
			if (soft_clear)
			begin
				for (int i = 0; i < 33; i++)
					sense_cfg[i] <= 5'h00;
			end
			else if (wr_sense)
				sense_cfg[sense_idx] <= pwdata[4:0];
		end
	end

	wire [31:0] rd_mux =
		(paddr == `EIU_PRIMARY_CONTROL_OFF)     ? {30'h0, global_enable, 1'b0} :
		(paddr == `EIU_SYNC_BUSY_STATUS_OFF)    ? {30'h0, enable_busy, soft_reset_busy} :
		(paddr == `EIU_LINE_ENABLE_CONTROL_OFF) ? line_enable_bits :
		(paddr == `EIU_IRQ_ENABLE_OFF)          ? {30'h0, irq_enable} :
		(paddr == `EIU_LINE_FLAG_STATUS_OFF)    ? line_flag_status :
		(paddr == `EIU_NMI_FLAG_OFF)            ? {31'h0, nmi_flag} :
		(paddr == `EIU_IRQ_STATUS_OFF)          ? {30'h0, irq_status} :
		sense_ok                                ? {27'h0, sense_cfg[sense_idx]} : 32'h0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata     <= 32'h0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			line_event <= 32'h0;
			line_irq   <= 32'h0;
			nmi_req    <= 1'b0;
			wake_req   <= 1'b0;
			irq        <= 1'b0;
		end
		else if (clk_en)
		begin
			pready     <= psel & ~pready;
			pslverr    <= psel & ~pready & ~known;
			if (rd_setup)
				prdata <= rd_mux;
			line_event <= flag_set;  // RULE7
			line_irq   <= line_flag_status;  // RULE2 RULE14
			nmi_req    <= nmi_flag;  // RULE8
			wake_req   <= |(async_hit & {global_enable, line_enable_bits} & {33{global_enable}});  // RULE5
			irq        <= |(irq_status & irq_enable);
		end
	end

endmodule : eiu_unit

`default_nettype wire

//--- verif/eiu_assertions.sv
/* concurrent checks on the pin interrupt unit: apb answer timing and request outputs.
 assumes one clock and a bind onto eiu_unit from the foot of this file. */
`timescale 1ns/1ns
`default_nettype none
module eiu_assertions
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] line_event,
	input wire logic [31:0] line_irq,
	input wire logic        irq
);
	wire flag_clear = psel && penable && pwrite && pready && (paddr == 12'h014);
	default clocking dclk @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	chk_zero_wait: assert property ((psel && !penable && clk_en) ##1 clk_en |-> pready)
		else $error("no answer in the first access cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_err_unmapped: assert property (pready && paddr > 12'h0c0 |-> pslverr)
		else $error("unmapped address answered without error");
	chk_mapped_ok: assert property (pready && (paddr == 12'h008 || paddr == 12'h014) |-> !pslverr)
		else $error("mapped register answered with error");
	chk_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");
	chk_quiet_release: assert property ($rose(presetn) |-> line_irq == 32'h0 && !irq && !pready)
		else $error("outputs active at reset release");
	chk_event_irq: assert property (|line_event |=> ($past(line_event) & ~line_irq) == 32'h0)
		else $error("event without matching request");
	chk_irq_release: assert property ($fell(|line_irq) |-> $past(flag_clear, 2))
		else $error("requests dropped without a flag clear");
endmodule : eiu_assertions
bind eiu_unit eiu_assertions i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .line_event(line_event), .line_irq(line_irq), .irq(irq));
`default_nettype wire

//--- verif/eiu_pin_source.sv
/* off-chip source model for the interrupt pins, push-pull, following the bench's wishes.
 assumes the sources are timed from pclk, as the unit's pins require. */
`timescale 1ns/1ns
`default_nettype none
module eiu_pin_source
(
	input  wire logic        pclk,
	input  wire logic [31:0] want_line,
	input  wire logic        want_nmi,
	output var  logic [31:0] external_line,
	output var  logic        nmi_line
);
	// pins hold a defined level from time zero so the unit never sees an unknown
	initial external_line = 32'h0000_0012;
	initial nmi_line = 1'b0;
	always @(posedge pclk)
	begin
		external_line <= want_line;
		nmi_line      <= want_nmi;
	end
endmodule : eiu_pin_source
`default_nettype wire

//--- verif/testbench.sv
/* self-checking bench of the pin interrupt unit: apb tasks, pin scenarios, register checks.
 assumes eiu_unit, the pin source and the bound checker compiled beforehand. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] want_line = 32'h0000_0012;
	logic        want_nmi = 1'b0;
	logic        clk_en = 1'b1;
	logic [31:0] prdata, line_event, line_irq, pins, rd;
	logic        pready, pslverr, nmi_line, nmi_req, wake_req, irq, err;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          events0 = 0;
	int          wakes = 0;
	// lines 0..7: rise, fall, both, high, low, rise filtered, rise async, rise (left disabled)
	logic [31:0] sense [8] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h9, 32'h11, 32'h1};
	always #4 pclk = ~pclk;
	eiu_pin_source i_pins (.pclk(pclk), .want_line(want_line), .want_nmi(want_nmi), .external_line(pins),
		.nmi_line(nmi_line));
	eiu_unit i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_line(pins), .nmi_line(nmi_line), .line_event(line_event), .line_irq(line_irq),
		.nmi_req(nmi_req), .wake_req(wake_req), .irq(irq));
	always @(posedge pclk)
	begin
		events0 += int'(line_event[0] === 1'b1);
		wakes += int'(wake_req === 1'b1);
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask : rchk
	task automatic poll_idle();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, 12'h004, 32'h0);
			n++;
		end
		while (rd !== 32'h0 && n < 20);
		cmp(rd, 32'h0);
	endtask : poll_idle
	task automatic pin(input logic [31:0] v, input int hold);
		@(posedge pclk);
		want_line <= v;
		repeat (hold) @(posedge pclk);
	endtask : pin
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// the tests need well under a thousand cycles; this leaves ample slack
	initial
	begin
		#200000;
		error_cnt++;
		summarize();
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rchk(12'h004, 32'h0);
		rchk(12'h008, 32'h0);
		rchk(12'h014, 32'h0);
		apb(1'b0, 12'hffc, 32'h0);
		cmp({31'h0, err}, 32'h1);
		cmp(rd, 32'h0);
		$display("test registers done");
		apb(1'b1, 12'h008, 32'h8000_005f);
		apb(1'b1, 12'h008, 32'h0000_0020);
		apb(1'b1, 12'h008, 32'h0000_0000);
		rchk(12'h008, 32'h8000_007f);
		for (int i = 0; i < 8; i++)
			apb(1'b1, 12'h040 + 12'(4 * i), sense[i]);
		apb(1'b1, 12'h00c, 32'h3);
		apb(1'b1, 12'h000, 32'h2);
		rchk(12'h004, 32'h2);
		poll_idle();
		$display("test setup done");
		pin(32'h0000_0032, 1);
		pin(32'h0000_0012, 8);
		rchk(12'h014, 32'h0);
		pin(32'h0000_00cd, 8);
		rchk(12'h014, 32'h0000_005f);
		pin(32'h0000_00ed, 8);
		rchk(12'h014, 32'h0000_007f);
		cmp(line_irq, 32'h0000_007f);
		cmp({31'h0, irq}, 32'h1);
		cmp(32'(events0 > 0), 32'h1);
		cmp(32'(wakes), 32'h1);
		// level lines still active set again, since a new hit outranks the clear
		apb(1'b1, 12'h014, 32'h0000_007f);
		rchk(12'h014, 32'h0000_0018);
		pin(32'h0000_0012, 8);
		rchk(12'h014, 32'h0000_001c);
		apb(1'b1, 12'h014, 32'h0000_001c);
		pin(32'h0000_0012, 4);
		cmp(line_irq, 32'h0);
		$display("test lines done");
		apb(1'b1, 12'h0c0, 32'h1);
		want_nmi <= 1'b1;
		pin(32'h0000_0012, 8);
		cmp({31'h0, nmi_req}, 32'h1);
		rchk(12'h01c, 32'h1);
		want_nmi <= 1'b0;
		apb(1'b1, 12'h01c, 32'h1);
		apb(1'b1, 12'h024, 32'h3);
		pin(32'h0000_0012, 4);
		cmp({30'h0, nmi_req, irq}, 32'h0);
		$display("test nmi done");
		apb(1'b1, 12'h000, 32'h1);
		rchk(12'h004, 32'h1);
		poll_idle();
		rchk(12'h008, 32'h0);
		$display("test soft reset done");
		// a low clock enable across the setup edge only postpones the answer
		clk_en <= 1'b0;
		fork
			apb(1'b1, 12'h008, 32'h0000_0001);
			begin
				repeat (6) @(posedge pclk);
				cmp({31'h0, pready}, 32'h0);
				clk_en <= 1'b1;
			end
		join
		rchk(12'h008, 32'h0000_0001);
		$display("test clock enable done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
